/* src/stuc_timer.sv */
`include "stuc_regs.svh"
`default_nettype none
// Contract
// - up mode: period match clears count next tick
// - up cycle lasts period plus one ticks
// - compare match drives output per output mode
// - compare match with enable requests interrupt
// - period event updates every non-capture output per mode
// - period match with enable requests period interrupt
// - channel flag set when compare equals count
// - up mode period flag delayed, joins wrap
// - wrap flag on return to zero, interruptible
// - zero period: count to zero, then hold
// - period and compare registers 16 bits
// - compare n gives n tick pulse
// - continuous: free run, software adds interval
// - vector: 0 none, 2..8 channels, 10 wrap
// - up mode period match is count >= period
// - tick from predivider 1, 2, 4, 8
// - stop mode halts count, keeps control bits
module stuc_timer #(
  parameter int NCH = 5,
  parameter int CW  = 16
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [NCH-1:0] captureIn,
  output logic      [NCH-1:0] channelOutputPin,
  output logic                periodIrq,
  output logic                vectorIrq
);

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] base);
    regHit = (a >= base) && (a < base + 8'(4 * NCH)) && (a[1:0] == 2'h0);
  endfunction : regHit

  function automatic int regIdx(input logic [7:0] a, input logic [7:0] base);
    regIdx = int'((a - base) >> 2);
  endfunction : regIdx

  function automatic logic outAct(input logic [2:0] m, input logic cur, input logic eqx, input logic eqp);
    logic r;
    r = cur;
    if (eqx)
    begin
      unique case (m)
        `STUC_OM_OUT: r = cur;
        `STUC_OM_SET, `STUC_OM_SETRS: r = 1'b1;
        `STUC_OM_TGRS, `STUC_OM_TGL, `STUC_OM_TGST: r = ~cur;
        `STUC_OM_RST, `STUC_OM_RSST: r = 1'b0;
      endcase
    end
    if (eqp)
    begin
      // second half of the paired modes acts on the period event
      if (m == `STUC_OM_TGRS || m == `STUC_OM_SETRS)
        r = 1'b0;
      if (m == `STUC_OM_TGST || m == `STUC_OM_RSST)
        r = 1'b1;
    end
    outAct = r;
  endfunction : outAct

  stuc_pkg::stuc_ctl_s ctl;
  stuc_pkg::stuc_ctl_s next_ctl;
  stuc_pkg::stuc_chc_s chCtl [NCH];
  stuc_pkg::stuc_chc_s next_chCtl [NCH];
  logic [CW-1:0]       cmpReg [NCH];
  logic [CW-1:0]       next_cmpReg [NCH];
  logic [CW-1:0]       countRegister;
  logic [CW-1:0]       next_countRegister;
  logic [2:0]          preCnt;
  logic [2:0]          next_preCnt;
  logic                wrapFlag;
  logic                next_wrapFlag;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic [3:0]          latVec;
  logic [3:0]          next_latVec;
  logic [NCH-1:0]      capS1;
  logic [NCH-1:0]      capS2;
  logic [NCH-1:0]      capS3;

  logic                upMode;
  logic                running;
  logic                tick;
  logic                periodMatchSignal;
  logic                upClear;
  logic [CW-1:0]       cntNext;
  logic                wrapEvt;
  logic [NCH-1:0]      evt;
  logic [NCH-1:0]      capEdge;
  logic [3:0]          vec;
  logic                acc;
  logic                setup;
  logic                mapped;
  logic [2:0]          divMax;

  assign upMode = (ctl.mode == stuc_pkg::STUC_UP);
  assign periodMatchSignal = upMode && (countRegister >= cmpReg[0]);
  assign upClear = periodMatchSignal && (cmpReg[0] != '0);
  // zero period: stop once the count has come round to zero
  assign running = (ctl.mode == stuc_pkg::STUC_CONT) ||
                   (upMode && !(cmpReg[0] == '0 && countRegister == '0));
  assign divMax = 3'((4'h1 << ctl.div) - 4'h1);
  assign tick = running && (preCnt == divMax);
  assign cntNext = upClear ? '0 : countRegister + 1'b1;
  assign wrapEvt = tick && (cntNext == '0);
  assign capEdge = capS2 & ~capS3;
  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign mapped = (paddr == `STUC_OFF_CTL) || (paddr == `STUC_OFF_CNT) || (paddr == `STUC_OFF_VEC) ||
                  regHit(paddr, `STUC_OFF_CHC) || regHit(paddr, `STUC_OFF_CMP);
  assign pslverr = acc && !mapped;

  // events happen on the edge where the count takes its new value
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      evt[i] = tick && (cntNext == cmpReg[i]);
    if (upMode)
      evt[0] = tick && upClear;
  end

  // priority: lowest channel first, wrap last
  always_comb
  begin
    vec = `STUC_VEC_NONE;
    if (wrapFlag && ctl.wrapIe)
      vec = `STUC_VEC_WRAP;
    for (int i = NCH - 1; i >= 1; i--)
      if (i <= 4 && chCtl[i].flag && chCtl[i].ie)
        vec = 4'(2 * i);
  end

  assign periodIrq = chCtl[0].flag && chCtl[0].ie;
  assign vectorIrq = (vec != `STUC_VEC_NONE);
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      channelOutputPin[i] = chCtl[i].out;
  end

  always_comb
  begin
    next_ctl = ctl;
    next_chCtl = chCtl;
    next_cmpReg = cmpReg;
    next_countRegister = countRegister;
    next_preCnt = preCnt;
    next_wrapFlag = wrapFlag;
    next_pready = setup;
    next_prdata = prdata;
    next_latVec = latVec;
    // stop mode freezes the predivider as well as the count
    if (tick)
    begin
      next_preCnt = '0;
      next_countRegister = cntNext;
    end
    else if (running)
      next_preCnt = preCnt + 3'h1;
    if (setup)
    begin
      // read data captured in setup so prdata leaves a flop
      next_prdata = '0;
      next_latVec = vec;
      if (paddr == `STUC_OFF_CTL)
        next_prdata = 32'(ctl);
      else if (paddr == `STUC_OFF_CNT)
        next_prdata = 32'(countRegister);
      else if (paddr == `STUC_OFF_VEC)
        next_prdata = 32'(vec);
      else if (regHit(paddr, `STUC_OFF_CHC))
        next_prdata = 32'(chCtl[regIdx(paddr, `STUC_OFF_CHC)]);
      else if (regHit(paddr, `STUC_OFF_CMP))
        next_prdata = 32'(cmpReg[regIdx(paddr, `STUC_OFF_CMP)]);
    end
    if (acc && pwrite)
    begin
      if (paddr == `STUC_OFF_CTL)
      begin
        next_ctl = stuc_pkg::stuc_ctl_s'(pwdata[4:0]);
        if (pwdata[`STUC_CTL_CLR_BIT])
        begin
          next_countRegister = '0;
          next_preCnt = '0;
        end
      end
      else if (paddr == `STUC_OFF_CNT)
        next_countRegister = pwdata[CW-1:0];
      else if (regHit(paddr, `STUC_OFF_CHC))
      begin
        // any write drops the overrun flag
        next_chCtl[regIdx(paddr, `STUC_OFF_CHC)] = stuc_pkg::stuc_chc_s'(pwdata[7:0] & 8'hBF);
      end
      else if (regHit(paddr, `STUC_OFF_CMP))
        next_cmpReg[regIdx(paddr, `STUC_OFF_CMP)] = pwdata[CW-1:0];
    end
    if (acc && !pwrite && paddr == `STUC_OFF_VEC)
    begin
      // reading the vector acknowledges the source it reported
      if (latVec == `STUC_VEC_WRAP)
        next_wrapFlag = 1'b0;
      else if (latVec != `STUC_VEC_NONE)
        next_chCtl[int'(latVec >> 1)].flag = 1'b0;
    end
    // events last, so a set beats a same-cycle clear
    if (wrapEvt)
      next_wrapFlag = 1'b1;
    for (int i = 0; i < NCH; i++)
    begin
      if (chCtl[i].cap && !(upMode && i == 0))
      begin
        if (capEdge[i])
        begin
          next_cmpReg[i] = countRegister;
          if (chCtl[i].flag)
            next_chCtl[i].ovr = 1'b1;
          next_chCtl[i].flag = 1'b1;
        end
      end
      else
      begin
        if (evt[i])
          next_chCtl[i].flag = 1'b1;
        next_chCtl[i].out = outAct(next_chCtl[i].omode, next_chCtl[i].out,
                                   evt[i], evt[0]);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctl <= stuc_pkg::stuc_ctl_s'(`STUC_RST_CTL);
      countRegister <= `STUC_RST_CNT;
      preCnt <= '0;
      wrapFlag <= 1'b0;
      pready <= 1'b0;
      prdata <= '0;
      latVec <= `STUC_VEC_NONE;
      capS1 <= '0;
      capS2 <= '0;
      capS3 <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        chCtl[i] <= stuc_pkg::stuc_chc_s'(`STUC_RST_CHC);
        cmpReg[i] <= '0;
      end
    end
    else
    begin
      ctl <= next_ctl;
      countRegister <= next_countRegister;
      preCnt <= next_preCnt;
      wrapFlag <= next_wrapFlag;
      pready <= next_pready;
      prdata <= next_prdata;
      latVec <= next_latVec;
      capS1 <= captureIn;
      capS2 <= capS1;
      capS3 <= capS2;
      chCtl <= next_chCtl;
      cmpReg <= next_cmpReg;
    end
  end

endmodule : stuc_timer
`default_nettype wire

/* inc/stuc_regs.svh */
`ifndef STUC_REGS_SVH
`define STUC_REGS_SVH
// byte offsets on the register bus
`define STUC_OFF_CTL 8'h00
`define STUC_OFF_CNT 8'h04
`define STUC_OFF_VEC 8'h08
`define STUC_OFF_CHC 8'h10
`define STUC_OFF_CMP 8'h30
// field positions in the global control word
`define STUC_CTL_CLR_BIT 5
// channel output modes
`define STUC_OM_OUT 3'h0
`define STUC_OM_SET 3'h1
`define STUC_OM_TGRS 3'h2
`define STUC_OM_SETRS 3'h3
`define STUC_OM_TGL 3'h4
`define STUC_OM_RST 3'h5
`define STUC_OM_TGST 3'h6
`define STUC_OM_RSST 3'h7
// vector codes
`define STUC_VEC_NONE 4'h0
`define STUC_VEC_WRAP 4'hA
// reset values
`define STUC_RST_CTL 5'h00
`define STUC_RST_CHC 8'h00
`define STUC_RST_CNT 16'h0000
`endif

/* inc/stuc_pkg.sv */
`default_nettype none
package stuc_pkg;
  typedef enum logic [1:0] {STUC_STOP, STUC_UP, STUC_CONT, STUC_RSVD} stuc_mode_e;
  typedef struct packed {
    logic [1:0] div;
    logic       wrapIe;
    stuc_mode_e mode;
  } stuc_ctl_s;
  typedef struct packed {
    logic       out;
    logic       ovr;
    logic       cap;
    logic [2:0] omode;
    logic       flag;
    logic       ie;
  } stuc_chc_s;
endpackage : stuc_pkg
`default_nettype wire

/* test/stuc_timer_assertions.sv */
`default_nettype none
module stuc_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        vectorIrq
);
  logic rdSet;
  logic rdEnd;
  assign rdSet = psel && !penable && !pwrite;
  assign rdEnd = psel && penable && pready && !pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; psel && penable && paddr == 8'hFC |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped");
  property p_vc; rdEnd && paddr == 8'h08 |-> prdata[31:4] == 28'h0 && !prdata[0] && prdata[3:0] <= 4'hA; endproperty
  a_vc: assert property (p_vc) else $error("bad code");
  property p_vz; rdSet && paddr == 8'h08 && !vectorIrq |=> prdata == 32'h0; endproperty
  a_vz: assert property (p_vz) else $error("code not 0");
  property p_vs; rdSet && paddr == 8'h08 && vectorIrq |=> prdata != 32'h0; endproperty
  a_vs: assert property (p_vs) else $error("code 0");
  property p_cw; rdEnd && paddr[7:4] == 4'h3 |-> prdata[31:16] == 16'h0; endproperty
  a_cw: assert property (p_cw) else $error("cmp wide");
  property p_nw; rdEnd && paddr == 8'h04 |-> prdata[31:16] == 16'h0; endproperty
  a_nw: assert property (p_nw) else $error("cnt wide");
endmodule : stuc_chk
bind stuc_timer stuc_chk stuc_chk_inst (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .vectorIrq);
`default_nettype wire

/* test/stuc_timer_tb.sv */
`default_nettype none
module stuc_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic [31:0] prev;
  logic [31:0] vexp [4] = '{32'h2, 32'h4, 32'hA, 32'h0};
  logic        pready;
  logic        periodIrq;
  logic [4:0]  pins;
  logic [4:0]  capIn = 5'h00;
  int          miscompares = 0;
  int          comparisons = 0;
  int          hi;
  int          lo;
  stuc_timer stuc_timer_inst (.clk, .sys_rst(rst), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr(), .captureIn(capIn), .channelOutputPin(pins), .periodIrq, .vectorIrq());
  initial forever #50 clk = ~clk;
  task final_report;
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  task bail;
    miscompares++;
    final_report();
  endtask : bail
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    miscompares += int'(g !== e);
    if (g !== e)
      $display("BAD %s exp %0h got %0h", nm, e, g);
  endtask : chk
  // reads land in rdat; ready and data taken at the same rising edge
  task bus(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      bail();
    rdat = prdata;
    {psel, penable} <= 2'b00;
  endtask : bus
  task waitpin(input logic v, output int n);
    @(negedge clk);
    for (n = 1; pins[1] !== v && n < 400; n++)
      @(negedge clk);
    if (n == 400)
      bail();
  endtask : waitpin
  task pwm_up;
    bus(8'h30, 32'h4);
    bus(8'h34, 32'h2);
    bus(8'h14, 32'h1C);
    for (int d = 0; d < 4; d++)
    begin
      bus(8'h00, 32'h21 | 32'(d << 3));
      // first edges after the clear are partial, so skip them
      waitpin(1'b0, hi);
      waitpin(1'b1, hi);
      waitpin(1'b0, hi);
      waitpin(1'b1, lo);
      chk("high", 2 << d, hi);
      chk("cycle", 5 << d, hi + lo);
    end
  endtask : pwm_up
  task flags_vector;
    bus(8'h38, 32'h3);
    for (int i = 0; i < 3; i++)
      bus(8'h10 + 8'(4 * i), 32'h1);
    bus(8'h00, 32'h25);
    repeat (20) @(posedge clk);
    bus(8'h00, 32'h04);
    @(negedge clk);
    chk("pirq", 32'h1, {31'h0, periodIrq});
    for (int i = 0; i < 4; i++)
    begin
      bus(8'h08, 32'h0, 1'b0);
      chk("vector", vexp[i], rdat);
    end
    bus(8'h04, 32'h0, 1'b0);
    prev = rdat;
    bus(8'h04, 32'h0, 1'b0);
    chk("stop", prev, rdat);
    bus(8'hFC, 32'h0, 1'b0);
  endtask : flags_vector
  task zero_period;
    bus(8'h00, 32'h0);
    bus(8'h04, 32'hFFF0);
    bus(8'h30, 32'h0);
    bus(8'h00, 32'h1);
    repeat (40) @(posedge clk);
    bus(8'h04, 32'h0, 1'b0);
    chk("hold", 32'h0, rdat);
  endtask : zero_period
  task continuous_run;
    // stale wrap from the zero period run must go before the wrap check
    bus(8'h00, 32'h04);
    bus(8'h14, 32'h10);
    bus(8'h18, 32'h0);
    bus(8'h08, 32'h0, 1'b0);
    chk("zwrap", 32'hA, rdat);
    bus(8'h04, 32'hFFFE);
    bus(8'h34, 32'h2);
    bus(8'h00, 32'h06);
    repeat (12) @(posedge clk);
    bus(8'h08, 32'h0, 1'b0);
    chk("wrap", 32'hA, rdat);
    @(negedge clk);
    chk("tgl", 32'h1, {31'h0, pins[1]});
    bus(8'h34, 32'h0, 1'b0);
    chk("cmp", 32'h2, rdat);
    bus(8'h34, rdat + 32'h40);
    repeat (80) @(negedge clk);
    chk("next", 32'h0, {31'h0, pins[1]});
  endtask : continuous_run
  task capture_overrun;
    bus(8'h1C, 32'h20);
    // two edges without a clear: second one marks overrun
    repeat (2)
    begin
      @(posedge clk);
      capIn <= 5'h08;
      repeat (4) @(posedge clk);
      capIn <= 5'h00;
      repeat (4) @(posedge clk);
    end
    for (int i = 0; i < 2; i++)
    begin
      bus(8'h1C, 32'h0, 1'b0);
      chk("ovr", 32'h62, rdat);
    end
    bus(8'h1C, 32'h20);
    bus(8'h1C, 32'h0, 1'b0);
    chk("ovrclr", 32'h20, rdat);
  endtask : capture_overrun
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pwm_up();
    flags_vector();
    zero_period();
    continuous_run();
    capture_overrun();
    final_report();
  end
endmodule : stuc_timer_tb
`default_nettype wire
